// *** src/mam_pkg.sv ***
// Package: register map, field positions and reset values of the alert/mask logic
package mam_pkg;
  localparam logic [7:0]  MAM_REG_CONFIG      = 8'h00;
  localparam logic [7:0]  MAM_REG_SHUNT       = 8'h01;
  localparam logic [7:0]  MAM_REG_BUS         = 8'h02;
  localparam logic [7:0]  MAM_REG_POWER       = 8'h03;
  localparam logic [7:0]  MAM_REG_CURRENT     = 8'h04;
  localparam logic [7:0]  MAM_REG_MASK_EN     = 8'h06;
  localparam logic [7:0]  MAM_REG_LIMIT       = 8'h07;
  localparam int          MAM_BIT_SHUNT_OVER  = 15;
  localparam int          MAM_BIT_SHUNT_UNDER = 14;
  localparam int          MAM_BIT_BUS_OVER    = 13;
  localparam int          MAM_BIT_BUS_UNDER   = 12;
  localparam int          MAM_BIT_POWER_OVER  = 11;
  localparam int          MAM_BIT_READY_EN    = 10;
  localparam int          MAM_BIT_MEM_FAULT   = 5;
  localparam int          MAM_BIT_LIMIT_FLAG  = 4;
  localparam int          MAM_BIT_DONE_FLAG   = 3;
  localparam int          MAM_BIT_OVF_FLAG    = 2;
  localparam int          MAM_BIT_SENSE       = 1;
  localparam int          MAM_BIT_LATCH       = 0;
  localparam logic [15:0] MAM_MASK_EN_RESET   = 16'h0000;
  localparam logic [15:0] MAM_LIMIT_RESET     = 16'h0000;
  localparam logic [15:0] MAM_RESULT_RESET    = 16'h0000;
  localparam logic [2:0]  MAM_MODE_PD_LOW     = 3'h0;
  localparam logic [2:0]  MAM_MODE_PD_HIGH    = 3'h4;
  localparam logic [15:0] MAM_WR_MASK         = 16'hfc03;
  localparam int          MAM_SYNC_STAGES     = 2;

  typedef enum logic [4:0] {
    MAM_SEL_SHUNT_OVER  = 5'h10,
    MAM_SEL_SHUNT_UNDER = 5'h08,
    MAM_SEL_BUS_OVER    = 5'h04,
    MAM_SEL_BUS_UNDER   = 5'h02,
    MAM_SEL_POWER_OVER  = 5'h01
  } mam_sel_t;

  // Keep only the highest-priority enable of the five compare functions
  function automatic logic [4:0] mam_prio(input logic [4:0] req);
    logic [4:0] res;
    res = 5'h00;
    if (req[4]) begin
      res = 5'h10;
    end else if (req[3]) begin
      res = 5'h08;
    end else if (req[2]) begin
      res = 5'h04;
    end else if (req[1]) begin
      res = 5'h02;
    end else if (req[0]) begin
      res = 5'h01;
    end
    return res;
  endfunction
endpackage

// *** src/mam_sync.sv ***
// Two-flop synchroniser for a level coming from a pin
`timescale 1ns/1ps
module mam_sync
  import mam_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic rst_b_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic [MAM_SYNC_STAGES-1:0] stage;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stage <= '0;
    end else begin
      stage <= {stage[MAM_SYNC_STAGES-2:0], d_in};
    end
  end

  assign q_out = stage[MAM_SYNC_STAGES-1];
endmodule

// *** src/mam_compare.sv ***
// Limit comparator for the selected alert function
`timescale 1ns/1ps
module mam_compare
  import mam_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic [4:0]       sel_in,
  input  wire logic [WIDTH-1:0] shunt_in,
  input  wire logic [WIDTH-1:0] bus_in,
  input  wire logic [WIDTH-1:0] power_in,
  input  wire logic [WIDTH-1:0] limit_in,
  output logic                  hit_out
);
  wire logic shunt_gt = $signed(shunt_in) > $signed(limit_in);
  wire logic shunt_lt = $signed(shunt_in) < $signed(limit_in);
  wire logic bus_gt   = bus_in > limit_in;
  wire logic bus_lt   = bus_in < limit_in;
  wire logic power_gt = power_in > limit_in;

  assign hit_out = (sel_in[4] & shunt_gt) | (sel_in[3] & shunt_lt) | (sel_in[2] & bus_gt) |
                   (sel_in[1] & bus_lt) | (sel_in[0] & power_gt);
endmodule

// *** src/mam_top.sv ***
// Alert and status logic of a current/voltage/power monitor
`timescale 1ns/1ps
module mam_top
  import mam_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_b_in,
  // Register port from the serial bus engine
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic [15:0]      reg_wdata_in,
  output logic      [15:0]      reg_rdata_out,
  // Result updates from the conversion and arithmetic engine
  input  wire logic             result_upd_in,
  input  wire logic             cycle_done_in,
  input  wire logic             math_ovf_in,
  input  wire logic             mem_fault_in,
  input  wire logic [WIDTH-1:0] shunt_in,
  input  wire logic [WIDTH-1:0] bus_in,
  input  wire logic [WIDTH-1:0] power_in,
  input  wire logic [WIDTH-1:0] current_in,
  // Alert pin: open-drain low drive or active-high push-pull
  output logic                  alert_out,
  output logic                  alert_oe_b_out
);
  // ==========================================================
  // Registers
  logic [4:0]       func_en;
  logic             ready_alert_en;
  logic             alert_sense_select;
  logic             alert_latch_select;
  logic             limit_alert_flag;
  logic             conversion_done_flag;
  logic             math_overflow_flag;
  logic [WIDTH-1:0] limit;
  logic [WIDTH-1:0] shunt_q;
  logic [WIDTH-1:0] bus_q;
  logic [WIDTH-1:0] power_q;
  logic [WIDTH-1:0] current_q;
  logic             memory_integrity_fault;
  logic             ready_alert;

  // ==========================================================
  // Decode
  wire logic       wr_mask   = reg_wr_in && (reg_addr_in == MAM_REG_MASK_EN);
  wire logic       wr_limit  = reg_wr_in && (reg_addr_in == MAM_REG_LIMIT);
  wire logic       wr_config = reg_wr_in && (reg_addr_in == MAM_REG_CONFIG);
  wire logic       rd_mask   = reg_rd_in && (reg_addr_in == MAM_REG_MASK_EN);
  wire logic [2:0] cfg_mode  = reg_wdata_in[2:0];
  wire logic       cfg_pd    = (cfg_mode == MAM_MODE_PD_LOW) || (cfg_mode == MAM_MODE_PD_HIGH);
  wire logic       clr_done  = (wr_config && !cfg_pd) || rd_mask;
  wire logic [4:0] wr_funcs  = reg_wdata_in[MAM_BIT_SHUNT_OVER:MAM_BIT_POWER_OVER];
  // Higher-priority enable blocks any lower one
  wire logic [4:0] next_func_en = mam_prio(wr_funcs);

  // Combined alert source is computed from the result that is being loaded
  logic hit;

  mam_compare #(
    .WIDTH (WIDTH)
  ) u_compare (
    .sel_in   (func_en),
    .shunt_in (shunt_in),
    .bus_in   (bus_in),
    .power_in (power_in),
    .limit_in (limit),
    .hit_out  (hit)
  );

  mam_sync u_mem_sync (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .d_in     (mem_fault_in),
    .q_out    (memory_integrity_fault)
  );

  // ==========================================================
  // Configuration
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      func_en            <= MAM_MASK_EN_RESET[MAM_BIT_SHUNT_OVER:MAM_BIT_POWER_OVER];
      ready_alert_en     <= MAM_MASK_EN_RESET[MAM_BIT_READY_EN];
      alert_sense_select <= MAM_MASK_EN_RESET[MAM_BIT_SENSE];
      alert_latch_select <= MAM_MASK_EN_RESET[MAM_BIT_LATCH];
      limit              <= MAM_LIMIT_RESET;
    end else begin
      if (wr_mask) begin
        func_en            <= next_func_en;
        ready_alert_en     <= reg_wdata_in[MAM_BIT_READY_EN];
        alert_sense_select <= reg_wdata_in[MAM_BIT_SENSE];
        alert_latch_select <= reg_wdata_in[MAM_BIT_LATCH];
      end
      if (wr_limit) begin
        limit <= reg_wdata_in;
      end
    end
  end

  // ==========================================================
  // Result holding registers
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      shunt_q   <= MAM_RESULT_RESET;
      bus_q     <= MAM_RESULT_RESET;
      power_q   <= MAM_RESULT_RESET;
      current_q <= MAM_RESULT_RESET;
    end else if (result_upd_in) begin
      shunt_q   <= shunt_in;
      bus_q     <= bus_in;
      power_q   <= power_in;
      current_q <= current_in;
    end
  end

  // ==========================================================
  // Status flags; a set in the same cycle as a clear wins
  wire logic next_limit_flag =
      (result_upd_in && hit) ? 1'b1 :
      (result_upd_in && !alert_latch_select) ? 1'b0 :
      (rd_mask && alert_latch_select) ? 1'b0 : limit_alert_flag;

  wire logic next_done_flag =
      cycle_done_in ? 1'b1 : (clr_done ? 1'b0 : conversion_done_flag);

  // Ready alert follows the flag in transparent mode, held until mask read if latched
  wire logic next_ready_alert =
      (cycle_done_in && ready_alert_en) ? 1'b1 :
      (!alert_latch_select && !conversion_done_flag) ? 1'b0 :
      (!alert_latch_select && clr_done) ? 1'b0 :
      (rd_mask) ? 1'b0 : (ready_alert && ready_alert_en);

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      limit_alert_flag     <= 1'b0;
      conversion_done_flag <= 1'b0;
      math_overflow_flag   <= 1'b0;
      ready_alert          <= 1'b0;
    end else begin
      limit_alert_flag     <= next_limit_flag;
      conversion_done_flag <= next_done_flag;
      ready_alert          <= next_ready_alert;
      if (math_ovf_in) begin
        math_overflow_flag <= 1'b1;
      end else if (result_upd_in) begin
        math_overflow_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Alert pin
  wire logic alert_active = next_limit_flag || next_ready_alert;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      alert_out      <= 1'b0;
      alert_oe_b_out <= 1'b1;
    end else begin
      alert_out      <= alert_sense_select & alert_active;
      alert_oe_b_out <= alert_sense_select ? 1'b0 : !alert_active;
    end
  end

  // ==========================================================
  // Read data
  wire logic [15:0] mask_rd = {func_en, ready_alert_en, 4'h0, memory_integrity_fault,
                               limit_alert_flag, conversion_done_flag, math_overflow_flag,
                               alert_sense_select, alert_latch_select};
  logic [15:0] rd_mux;

  always_comb begin
    unique case (reg_addr_in)
      MAM_REG_SHUNT:   rd_mux = 16'(shunt_q);
      MAM_REG_BUS:     rd_mux = 16'(bus_q);
      MAM_REG_POWER:   rd_mux = 16'(power_q);
      MAM_REG_CURRENT: rd_mux = 16'(current_q);
      MAM_REG_MASK_EN: rd_mux = mask_rd;
      MAM_REG_LIMIT:   rd_mux = 16'(limit);
      default:         rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mux;
    end
  end
endmodule

// *** verification/mam_properties.sv ***
// Checker: port-level properties of the alert and status logic
`timescale 1ns/1ps
module mam_properties
  import mam_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic             mclk_in,
  input wire logic             rst_b_in,
  input wire logic             reg_wr_in,
  input wire logic             reg_rd_in,
  input wire logic [7:0]       reg_addr_in,
  input wire logic [15:0]      reg_wdata_in,
  input wire logic [15:0]      reg_rdata_out,
  input wire logic             result_upd_in,
  input wire logic             cycle_done_in,
  input wire logic [WIDTH-1:0] shunt_in,
  input wire logic             alert_out,
  input wire logic             alert_oe_b_out
);
  // ====================
  // Shadow of the writable fields
  logic [15:0] mask_h;
  logic [15:0] limit_h;
  logic [4:0]  top_en;
  wire         act = mask_h[MAM_BIT_SENSE] ? alert_out : !alert_oe_b_out;
  wire         rd_m = reg_rd_in && reg_addr_in == MAM_REG_MASK_EN;
  wire         quiet = !cycle_done_in && !result_upd_in;
  always_comb begin
    casez (reg_wdata_in[15:11])
      5'b1????: top_en = 5'h10;
      5'b01???: top_en = 5'h08;
      5'b001??: top_en = 5'h04;
      5'b0001?: top_en = 5'h02;
      default:  top_en = {4'h0, reg_wdata_in[11]};
    endcase
  end
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mask_h  <= 16'h0000;
      limit_h <= 16'h0000;
    end else if (reg_wr_in && reg_addr_in == MAM_REG_MASK_EN) begin
      mask_h <= {top_en, reg_wdata_in[10], 8'h00, reg_wdata_in[1:0]};
    end else if (reg_wr_in && reg_addr_in == MAM_REG_LIMIT) begin
      limit_h <= reg_wdata_in;
    end
  end
  // ====================
  // Properties
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_mrd;
    rd_m && quiet;
  endsequence
  a_mask_fields: assert property (rd_m |=> reg_rdata_out[15:10] == mask_h[15:10])
    else $error("mask enables read wrong");
  a_shunt_over: assert property (mask_h[15] && result_upd_in &&
    $signed(shunt_in) > $signed(limit_h) |=> act) else $error("no alert on shunt over");
  a_sense_high: assert property (mask_h[1] && $past(mask_h[1]) |-> !alert_oe_b_out)
    else $error("pin released in high sense");
  a_sense_low: assert property (!mask_h[1] && !$past(mask_h[1]) |-> !alert_out)
    else $error("pin level high in low sense");
  a_read_clears: assert property (s_mrd ##1 (quiet && !reg_rd_in) ##1 s_mrd |=>
    !reg_rdata_out[3] && (!mask_h[0] || !reg_rdata_out[4])) else $error("flag not cleared");
  a_done_sets: assert property (cycle_done_in ##1 (!reg_rd_in && !reg_wr_in) ##1 s_mrd
    |=> reg_rdata_out[3]) else $error("done flag missing");
  a_ready_alert: assert property (mask_h[10] && cycle_done_in |=> act)
    else $error("no ready alert");
  a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved");
endmodule

// *** verification/mam_host_model.sv ***
// Host model: register master on the block's register port
`timescale 1ns/1ps
module mam_host_model (
  input  wire logic        mclk_in,
  input  wire logic [15:0] rdata_in,
  output logic             wr_out,
  output logic             rd_out,
  output logic [7:0]       addr_out,
  output logic [15:0]      wdata_out
);
  initial begin
    {wr_out, rd_out, addr_out, wdata_out} = '0;
  end
  // Released lines carry the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    #1 {wr_out, addr_out, wdata_out} = {1'b1, a, d};
    @(posedge mclk_in);
    #1 {wr_out, addr_out, wdata_out} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk_in);
    #1 {rd_out, addr_out} = {1'b1, a};
    @(posedge mclk_in);
    #1 {rd_out, addr_out} = {1'b0, ~a};
    d = rdata_in;
  endtask
endmodule

// *** verification/mam_top_tb.sv ***
// Testbench: register and alert scenarios for the alert/mask logic
`timescale 1ns/1ps
module mam_top_tb;
  import mam_pkg::*;
  logic        mclk_in;
  logic        rst_b_in = 1'b0;
  logic        upd = 1'b0;
  logic        done = 1'b0;
  logic        ovf = 1'b0;
  logic        wr, rd, alert, oe_b;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, rv;
  logic [15:0] sh = 16'h0, bu = 16'h0, pw = 16'h0;
  logic [15:0] hs [5] = '{16'h0020, 16'hfff0, 16'h0010, 16'h0010, 16'h0010};
  logic [15:0] hb [5] = '{16'h0010, 16'h0010, 16'h0020, 16'h0005, 16'h0010};
  logic [15:0] hp [5] = '{16'h0010, 16'h0010, 16'h0010, 16'h0010, 16'h0020};
  int          n_fail = 0, n_tests = 0, cyc = 0;
  mam_top i_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .result_upd_in(upd),
    .cycle_done_in(done), .math_ovf_in(ovf), .mem_fault_in(1'b0), .shunt_in(sh),
    .bus_in(bu), .power_in(pw), .current_in(~sh), .alert_out(alert), .alert_oe_b_out(oe_b));
  mam_host_model i_host (.mclk_in(mclk_in), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
    .addr_out(addr), .wdata_out(wdata));
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic conv(input logic [15:0] s, b, p, input logic o);
    @(posedge mclk_in);
    #1 {sh, bu, pw, ovf, upd} = {s, b, p, o, 1'b1};
    @(posedge mclk_in);
    #1 {ovf, upd} = 2'b00;
  endtask
  task automatic pulse_done();
    @(posedge mclk_in);
    #1 done = 1'b1;
    @(posedge mclk_in);
    #1 done = 1'b0;
  endtask
  task automatic rdm(input logic [15:0] e);
    i_host.rd(MAM_REG_MASK_EN, rv);
    chk(rv, e);
  endtask
  // ====================
  // Sequence
  initial begin
    repeat (3) @(posedge mclk_in);
    #1 rst_b_in = 1'b1;
    rdm(MAM_MASK_EN_RESET);
    i_host.wr(MAM_REG_MASK_EN, 16'hffff);
    rdm(16'h8403);
    i_host.wr(MAM_REG_LIMIT, 16'h0010);
    for (int i = 0; i < 5; i++) begin
      i_host.wr(MAM_REG_MASK_EN, 16'h8000 >> i);
      conv(hs[i], hb[i], hp[i], 1'b0);
      chk({alert, oe_b}, 16'h0000);
      rdm((16'h8000 >> i) | 16'h0010);
      conv(16'h0010, 16'h0010, 16'h0010, 1'b0);
      rdm(16'h8000 >> i);
      chk({alert, oe_b}, 16'h0001);
    end
    i_host.wr(MAM_REG_MASK_EN, 16'h8001);
    conv(16'h0020, 16'h0010, 16'h0010, 1'b0);
    conv(16'h0010, 16'h0010, 16'h0010, 1'b0);
    chk({alert, oe_b}, 16'h0000);
    rdm(16'h8011);
    rdm(16'h8001);
    chk({alert, oe_b}, 16'h0001);
    i_host.wr(MAM_REG_MASK_EN, 16'h8002);
    conv(16'h0020, 16'h0010, 16'h0010, 1'b0);
    chk({alert, oe_b}, 16'h0002);
    conv(16'h0010, 16'h0010, 16'h0010, 1'b0);
    chk({alert, oe_b}, 16'h0000);
    i_host.wr(MAM_REG_MASK_EN, 16'h0400);
    pulse_done();
    chk({alert, oe_b}, 16'h0000);
    rdm(16'h0408);
    rdm(16'h0400);
    chk({alert, oe_b}, 16'h0001);
    pulse_done();
    i_host.wr(MAM_REG_CONFIG, 16'h0007);
    rdm(16'h0400);
    pulse_done();
    i_host.wr(MAM_REG_CONFIG, {13'h0, MAM_MODE_PD_HIGH});
    i_host.wr(MAM_REG_CONFIG, {13'h0, MAM_MODE_PD_LOW});
    rdm(16'h0408);
    i_host.wr(MAM_REG_MASK_EN, 16'h0000);
    pulse_done();
    chk({alert, oe_b}, 16'h0001);
    conv(16'h1234, 16'h0010, 16'h0010, 1'b1);
    rdm(16'h000c);
    i_host.rd(MAM_REG_SHUNT, rv);
    chk(rv, 16'h1234);
    i_host.rd(MAM_REG_BUS, rv);
    chk(rv, 16'h0010);
    i_host.rd(MAM_REG_POWER, rv);
    chk(rv, 16'h0010);
    i_host.rd(MAM_REG_CURRENT, rv);
    chk(rv, 16'hedcb);
    i_host.rd(MAM_REG_LIMIT, rv);
    chk(rv, 16'h0010);
    // Reset in mid-run returns every field and the pin to idle
    @(posedge mclk_in);
    #1 rst_b_in = 1'b0;
    @(posedge mclk_in);
    #1 rst_b_in = 1'b1;
    rdm(MAM_MASK_EN_RESET);
    chk({alert, oe_b}, 16'h0001);
    i_host.rd(MAM_REG_LIMIT, rv);
    chk(rv, MAM_LIMIT_RESET);
    finish_test();
  end
endmodule
bind mam_top mam_properties #(.WIDTH(WIDTH)) i_props (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .result_upd_in(result_upd_in),
  .cycle_done_in(cycle_done_in), .shunt_in(shunt_in), .alert_out(alert_out),
  .alert_oe_b_out(alert_oe_b_out));
